// *** logic/merge_arb_pkg.sv ***
// Purpose: shared constants and types for the conveyor merge arbiter
// Assumes: 32-bit APB, word-aligned registers
// Notes:   offsets are byte addresses
package merge_arb_pkg;
   localparam logic [7:0]  CTRL_OFF       = 8'h00;
   localparam logic [7:0]  ACCEPT_OFF     = 8'h04;
   localparam logic [7:0]  SEND_OFF       = 8'h08;
   localparam logic [7:0]  STATUS_OFF     = 8'h0C;
   localparam int          CTRL_EN_LEFT   = 0;
   localparam int          CTRL_EN_RIGHT  = 1;
   localparam int          CTRL_T_LEFT    = 2;
   localparam int          CTRL_T_RIGHT   = 3;
   localparam int          CTRL_PRIO_LSB  = 4;
   localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
   localparam logic [15:0] ACCEPT_RESET   = 16'h0019;
   localparam logic [15:0] SEND_RESET     = 16'h0019;
   localparam int          SRC_CENTER     = 0;
   localparam int          SRC_LEFT       = 1;
   localparam int          SRC_RIGHT      = 2;

   typedef enum logic [1:0]
   {
      PRIO_FCFS   = 2'b00,
      PRIO_CENTER = 2'b01,
      PRIO_LEFT   = 2'b10,
      PRIO_RIGHT  = 2'b11
   } prio_e;

   typedef enum logic [1:0]
   {
      ST_IDLE   = 2'b00,
      ST_GRANT  = 2'b01,
      ST_ACCEPT = 2'b10,
      ST_CLEAR  = 2'b11
   } state_e;

   typedef struct packed
   {
      logic [2:0] itemWaiting;
      logic       mergeBlocked;
      logic       downstreamOk;
   } sense_s;
endpackage

// *** logic/conveyor_merge_arbiter.sv ***
// Purpose: grants merge-zone entry to one of center, left, right source lines
// Assumes: sensor and permit inputs are asynchronous pins; one clock
// Notes:   registers over APB; timers count clock cycles
`timescale 1ns/1ps
`default_nettype none

module conveyor_merge_arbiter
   import merge_arb_pkg::*;
#(
   parameter int TIMER_W = 16
)
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        arst_n,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // source discharge sensors: bit0 center, bit1 left, bit2 right
   input  wire logic [2:0]  srcItem,
   // merge zone sensor and downstream permit
   input  wire logic        mergeSensor,
   input  wire logic        downstreamPermit,
   // release permissions and motor
   output logic [2:0]       srcRelease,
   output logic             mergeMotorRun
);
   import merge_arb_pkg::*;

   // synchronisers: the one merge zone sensor is this block's own zone, and
   // the permit comes from the zone directly downstream
   logic [4:0] syncA_reg;
   logic [4:0] syncB_reg;
   sense_s     sense;

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         syncA_reg <= 5'h00;
         syncB_reg <= 5'h00;
      end
      else
      begin
         syncA_reg <= {srcItem, mergeSensor, downstreamPermit};
         syncB_reg <= syncA_reg;
      end
   end

   assign sense = sense_s'(syncB_reg);

   // registers
   // only decoded offsets load; writes to unmapped offsets are dropped
   logic [31:0]        ctrl_reg;
   logic [TIMER_W-1:0] accept_reg;
   logic [TIMER_W-1:0] send_reg;

   wire        apbWrite  = psel && penable && pwrite;
   wire        hitCtrl   = (paddr == CTRL_OFF);
   wire        hitAccept = (paddr == ACCEPT_OFF);
   wire        hitSend   = (paddr == SEND_OFF);
   wire        hitStatus = (paddr == STATUS_OFF);
   wire        hitAny    = hitCtrl || hitAccept || hitSend || hitStatus;

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctrl_reg   <= CTRL_RESET;
         accept_reg <= TIMER_W'(ACCEPT_RESET);
         send_reg   <= TIMER_W'(SEND_RESET);
      end
      else if (apbWrite)
      begin
         if (hitCtrl)
            ctrl_reg <= {26'h0, pwdata[5:0]};
         if (hitAccept)
            accept_reg <= pwdata[TIMER_W-1:0];
         if (hitSend)
            send_reg <= pwdata[TIMER_W-1:0];
      end
   end

   // line enables and types: center always enabled
   wire [2:0] lineEn = {ctrl_reg[CTRL_EN_RIGHT], ctrl_reg[CTRL_EN_LEFT], 1'b1};
   wire [2:0] lineT  = {ctrl_reg[CTRL_T_RIGHT], ctrl_reg[CTRL_T_LEFT], 1'b0};
   prio_e     prio;
   assign prio = prio_e'(ctrl_reg[CTRL_PRIO_LSB +: 2]);

   // arbitration state
   state_e             state_reg;
   state_e             state_next;
   logic [2:0]         grant_reg;
   logic [2:0]         grant_next;
   logic [2:0]         waitOld_reg;
   logic [2:0]         age_reg [3];
   logic [TIMER_W-1:0] timer_reg;
   logic [TIMER_W-1:0] timer_next;

   // a line counts as waiting only when it is enabled
   wire [2:0] waiting = sense.itemWaiting & lineEn;

   // oldest among a candidate set; lowest index breaks ties
   function automatic logic [2:0] pickOldest(input logic [2:0] cand, input logic [2:0] age [3]);
      logic [2:0] best;
      logic [2:0] bestAge;
      best    = 3'b000;
      bestAge = 3'h0;
      for (int i = 0; i < 3; i++)
      begin
         if (cand[i] && (best == 3'b000 || age[i] > bestAge))
         begin
            best    = 3'b001 << i;
            bestAge = age[i];
         end
      end
      return best;
   endfunction

   // age counters order arrivals for first-come service
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (int i = 0; i < 3; i++)
            age_reg[i] <= 3'h0;
         waitOld_reg <= 3'b000;
      end
      else
      begin
         waitOld_reg <= waiting;
         for (int i = 0; i < 3; i++)
         begin
            if (!waiting[i])
               age_reg[i] <= 3'h0;
            else if (!waitOld_reg[i])
               age_reg[i] <= 3'h1;
            else if (age_reg[i] != 3'h7)
               age_reg[i] <= age_reg[i] + 3'h1;
         end
      end
   end

   // favoured line per mode
   logic [2:0] favoured;
   always_comb
   begin
      case (prio)
         PRIO_CENTER: favoured = 3'b001 << SRC_CENTER;
         PRIO_LEFT:   favoured = 3'b001 << SRC_LEFT;
         PRIO_RIGHT:  favoured = 3'b001 << SRC_RIGHT;
         default:     favoured = 3'b000;
      endcase
   end

   // favoured line wins if waiting, else first-come among the rest
   wire [2:0] favWait  = favoured & waiting;
   wire [2:0] fcfsPick = pickOldest(waiting & ~favoured, age_reg);
   wire [2:0] pick     = (favWait != 3'b000) ? favWait : fcfsPick;

   // favoured item arrives before the released item clears: keep it next
   wire       keepFav  = (grant_reg == favoured) && (favWait != 3'b000);
   wire       grantT   = |(grant_reg & lineT);
   wire       timerEnd = (timer_reg == '0);

   always_comb
   begin
      state_next = state_reg;
      grant_next = grant_reg;
      timer_next = timerEnd ? timer_reg : timer_reg - TIMER_W'(1);
      case (state_reg)
         ST_IDLE:
         begin
            // one grant at a time
            if (pick != 3'b000)
            begin
               grant_next = pick;
               state_next = ST_GRANT;
            end
         end
         ST_GRANT:
         begin
            // release stands while the item travels from its line onto the zone
            if (sense.mergeBlocked)
            begin
               // accept timer starts on merge sensor block
               timer_next = grantT ? accept_reg : '0;
               state_next = ST_ACCEPT;
            end
         end
         ST_ACCEPT:
         begin
            if (!sense.mergeBlocked)
            begin
               // send delay after the merge sensor clears
               timer_next = grantT ? send_reg : '0;
               state_next = ST_CLEAR;
            end
         end
         ST_CLEAR:
         begin
            if (timerEnd)
            begin
               // grant held until item clear of merge zone
               if (keepFav)
                  state_next = ST_GRANT;
               else
               begin
                  grant_next = 3'b000;
                  state_next = ST_IDLE;
               end
            end
         end
         default:
         begin
            state_next = ST_IDLE;
            grant_next = 3'b000;
         end
      endcase
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_reg <= ST_IDLE;
         grant_reg <= 3'b000;
         timer_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         grant_reg <= grant_next;
         timer_reg <= timer_next;
      end
   end

   // outputs
   logic [2:0] release_reg;
   logic       motor_reg;
   // T-merge: rollers stay stopped while the item is thrown across, then for the accept time
   wire        holdThrow  = (state_reg == ST_GRANT) && grantT;
   wire        holdAccept = (state_reg == ST_ACCEPT) && grantT && !timerEnd;
   wire        motorHold  = holdThrow || holdAccept;
   // zone accumulation: the downstream permit gates the motor at all times
   wire        motorNext  = sense.downstreamOk && !motorHold && (state_reg != ST_IDLE);
   wire [2:0]  relNext   = (state_reg == ST_GRANT) ? grant_reg : 3'b000;

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         release_reg <= 3'b000;
         motor_reg   <= 1'b0;
         prdata      <= 32'h0000_0000;
      end
      else
      begin
         release_reg <= relNext;
         motor_reg   <= motorNext;
         if (psel && !penable && !pwrite)
         begin
            prdata <= hitCtrl   ? ctrl_reg :
                      hitAccept ? 32'(accept_reg) :
                      hitSend   ? 32'(send_reg) :
                      hitStatus ? {22'h0, sense.itemWaiting, grant_reg, state_reg, sense.mergeBlocked,
                                   sense.downstreamOk} :
                      32'h0000_0000;
         end
      end
   end

   assign srcRelease    = release_reg;
   assign mergeMotorRun = motor_reg;
   // zero wait states; unmapped offsets answer with an error in the access phase
   assign pready        = 1'b1;
   assign pslverr       = psel && penable && !hitAny;
endmodule

`default_nettype wire

// *** test/merge_arb_checker.sv ***
// Purpose: port assertions for the merge arbiter
// Assumes: inputs pass two sync stages
// Notes:   bound into every arbiter
`timescale 1ns/1ps
`default_nettype none
module merge_arb_checker
(
   // clock, reset, apb
   input wire logic       clock,
   input wire logic       arst_n,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic [7:0] paddr,
   input wire logic       pready,
   input wire logic       pslverr,
   // zone side
   input wire logic [2:0] srcItem,
   input wire logic       mergeSensor,
   input wire logic       downstreamPermit,
   input wire logic [2:0] srcRelease,
   input wire logic       mergeMotorRun
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   sequence permitLow; !downstreamPermit [*4]; endsequence
   sequence grantDrop; $past(srcRelease) != 3'h0 && srcRelease == 3'h0; endsequence
   chk_one_grant: assert property ($onehot0(srcRelease))
      else $error("two grants");
   chk_grant_kept: assert property (srcRelease != 3'h0 && $past(srcRelease) != 3'h0 |-> $stable(srcRelease))
      else $error("grant switched");
   chk_drop_blocked: assert property (grantDrop |-> $past(mergeSensor, 2))
      else $error("grant dropped early");
   chk_grant_waiting: assert property ((srcRelease & ~$past(srcRelease) & ~$past(srcItem, 3)) == 3'h0)
      else $error("grant without item");
   chk_motor_permit: assert property (permitLow |-> !mergeMotorRun)
      else $error("motor without permit");
   chk_motor_cause: assert property (mergeMotorRun |-> $past(downstreamPermit, 2) || $past(downstreamPermit, 3))
      else $error("motor cause");
   chk_ready_high: assert property (pready)
      else $error("ready low");
   chk_err_unmapped: assert property (psel && penable && paddr > 8'h0C |-> pslverr)
      else $error("no error");
endmodule
bind conveyor_merge_arbiter merge_arb_checker chk (.clock, .arst_n, .psel, .penable, .paddr, .pready, .pslverr,
   .srcItem, .mergeSensor, .downstreamPermit, .srcRelease, .mergeMotorRun);
`default_nettype wire

// *** test/merge_zone_model.sv ***
// Purpose: source lines and merge zone item travel
// Assumes: one item waits per line
// Notes:   item advances along the zone only while the motor runs
`timescale 1ns/1ps
`default_nettype none
module merge_zone_model
(
   // bench side
   input  wire logic       clock,
   input  wire logic       arst_n,
   input  wire logic [2:0] arrive,
   input  wire logic       slow,
   // arbiter side
   input  wire logic [2:0] srcRelease,
   input  wire logic       mergeMotorRun,
   output logic [2:0]      srcItem,
   output logic            mergeSensor
);
   logic [3:0] travelReg;
   logic [3:0] travelNext;
   logic [2:0] sendNow;
   // a line discharges only when released onto a clear zone
   assign sendNow    = srcRelease & srcItem & {3{!mergeSensor}};
   assign travelNext = travelReg + 4'h1;
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         srcItem     <= 3'h0;
         mergeSensor <= 1'h0;
         travelReg   <= 4'h0;
      end
      else
      begin
         srcItem <= (srcItem | arrive) & ~sendNow;
         if (sendNow != 3'h0)
         begin
            mergeSensor <= 1'h1;
            travelReg   <= 4'h0;
         end
         else if (mergeSensor && mergeMotorRun)
         begin
            travelReg   <= travelNext;
            mergeSensor <= travelNext != (slow ? 4'hC : 4'h3);
         end
      end
   end
endmodule
`default_nettype wire

// *** test/test_conveyor_merge_arbiter.sv ***
// Purpose: self-checking bench for the merge arbiter
// Assumes: no apb wait states
// Notes:   accept and send times set to 6 cycles
`timescale 1ns/1ps
`default_nettype none
module test_conveyor_merge_arbiter;
   import merge_arb_pkg::*;
   logic        clock = 1'h0;
   logic        arst_n = 1'h0;
   logic        psel = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite = 1'h0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [2:0]  srcItem;
   logic        mergeSensor;
   logic        downstreamPermit = 1'h1;
   logic [2:0]  srcRelease;
   logic        mergeMotorRun;
   logic [2:0]  arrive = 3'h0;
   logic        slow = 1'h0;
   int          fails = 0;
   int          n_compared = 0;
   always #20 clock = ~clock;
   conveyor_merge_arbiter dut (.clock, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .srcItem, .mergeSensor, .downstreamPermit, .srcRelease, .mergeMotorRun);
   merge_zone_model partner (.clock, .arst_n, .arrive, .slow, .srcRelease, .mergeMotorRun, .srcItem, .mergeSensor);
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic stall(input int i);
      if (i >= 400)
      begin
         check("wait", 32'h1, 32'h0);
         results();
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      int i;
      @(posedge clock);
      psel   <= 1'h1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      for (i = 0; i < 400; i++)
      begin
         @(posedge clock);
         if (pready === 1'h1)
            break;
      end
      stall(i);
      q = prdata;
      e = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask
   // 0 new grant other than v, 1 sensor equals v, 2 motor on, 3 all idle
   task automatic waitOn(input int m, input logic [2:0] v, output int n);
      for (n = 0; n < 400; n++)
      begin
         @(negedge clock);
         if (m == 0 ? srcRelease !== 3'h0 && srcRelease !== v : m == 1 ? mergeSensor === v[0] :
             m == 2 ? mergeMotorRun === 1'h1 : (srcItem | srcRelease) === 3'h0 && mergeSensor === 1'h0)
            break;
      end
      stall(n);
   endtask
   task automatic arb(input prio_e p, input logic [2:0] a, input logic [2:0] b, input logic [2:0] e1,
                      input logic [2:0] e2);
      logic [31:0] q;
      logic        e;
      int          n;
      apb(1'h1, CTRL_OFF, {26'h0, p, 4'h3}, q, e);
      @(posedge clock);
      arrive <= a;
      @(posedge clock);
      arrive <= b;
      @(posedge clock);
      arrive <= 3'h0;
      waitOn(0, 3'h0, n);
      check("first grant", {29'h0, e1}, {29'h0, srcRelease});
      waitOn(0, e1, n);
      check("next grant", {29'h0, e2}, {29'h0, srcRelease});
      waitOn(3, 3'h0, n);
      repeat (12) @(negedge clock);
   endtask
   task automatic t_regs;
      logic [31:0] q;
      logic        e;
      apb(1'h0, CTRL_OFF, 32'h0, q, e);
      check("ctrl reset", CTRL_RESET, q);
      apb(1'h0, ACCEPT_OFF, 32'h0, q, e);
      check("accept reset", {16'h0, ACCEPT_RESET}, q);
      apb(1'h0, SEND_OFF, 32'h0, q, e);
      check("send reset", {16'h0, SEND_RESET}, q);
      apb(1'h0, 8'h10, 32'h0, q, e);
      check("unmapped error", 32'h1, {31'h0, e});
      apb(1'h0, STATUS_OFF, 32'h0, q, e);
      check("status idle", 32'h0000_0001, q);
      check("status error", 32'h0, {31'h0, e});
   endtask
   task automatic t_keep;
      logic [31:0] q;
      logic        e;
      int          n;
      apb(1'h1, CTRL_OFF, {26'h0, PRIO_CENTER, 4'h3}, q, e);
      @(posedge clock);
      slow   <= 1'h1;
      arrive <= 3'h3;
      @(posedge clock);
      arrive <= 3'h0;
      waitOn(0, 3'h0, n);
      check("center first", 32'h1, {29'h0, srcRelease});
      waitOn(1, 3'h1, n);
      @(posedge clock);
      arrive <= 3'h1;
      @(posedge clock);
      arrive <= 3'h0;
      repeat (3) @(negedge clock);
      check("grant dropped", 32'h0, {29'h0, srcRelease});
      waitOn(0, 3'h0, n);
      check("center kept", 32'h1, {29'h0, srcRelease});
      waitOn(0, 3'h1, n);
      check("side after", 32'h2, {29'h0, srcRelease});
      waitOn(3, 3'h0, n);
      repeat (12) @(negedge clock);
   endtask
   task automatic t_tmerge;
      logic [31:0] q;
      logic        e;
      int          n;
      apb(1'h1, ACCEPT_OFF, 32'h6, q, e);
      apb(1'h1, SEND_OFF, 32'h6, q, e);
      apb(1'h1, CTRL_OFF, 32'h5, q, e);
      apb(1'h0, ACCEPT_OFF, 32'h0, q, e);
      check("accept write", 32'h6, q);
      @(posedge clock);
      arrive <= 3'h2;
      slow   <= 1'h1;
      @(posedge clock);
      arrive <= 3'h0;
      waitOn(1, 3'h1, n);
      waitOn(2, 3'h0, n);
      check("accept hold", 32'h1, 32'(n >= 6 && n <= 14));
      @(posedge clock);
      downstreamPermit <= 1'h0;
      arrive           <= 3'h2;
      repeat (6) @(negedge clock);
      check("motor stop", 32'h0, {31'h0, mergeMotorRun});
      @(posedge clock);
      downstreamPermit <= 1'h1;
      arrive           <= 3'h0;
      waitOn(1, 3'h0, n);
      waitOn(0, 3'h0, n);
      check("send wait", 32'h1, 32'(n >= 6 && n <= 14));
      waitOn(3, 3'h0, n);
   endtask
   initial
   begin
      repeat (20) @(posedge clock);
      arst_n <= 1'h1;
      t_regs();
      arb(PRIO_FCFS, 3'h4, 3'h2, 3'h4, 3'h2);
      arb(PRIO_FCFS, 3'h6, 3'h0, 3'h2, 3'h4);
      arb(PRIO_CENTER, 3'h7, 3'h0, 3'h1, 3'h2);
      arb(PRIO_CENTER, 3'h6, 3'h0, 3'h2, 3'h4);
      arb(PRIO_LEFT, 3'h7, 3'h0, 3'h2, 3'h1);
      arb(PRIO_RIGHT, 3'h7, 3'h0, 3'h4, 3'h1);
      t_keep();
      t_tmerge();
      results();
   end
endmodule
`default_nettype wire
